// ---- rtl/pdmm_int_src.sv ----
// One interrupt source: edge detection and a sticky request flag
// Assumes sig is already on sys_clk; clr and sw_we come from the same clock
`timescale 1ns/1ps

module pdmm_int_src (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Event input and its active edge
    input wire logic sig,
    input wire pdmm_pkg::pdmm_edge_t mode,
    // Flag control
    input wire logic clr,
    input wire logic sw_we,
    input wire logic sw_val,
    // Request flag
    output logic pend
);

    pdmm_pkg::pdmm_isrc_t s_reg;
    pdmm_pkg::pdmm_isrc_t s_next;
    logic [1:0] m;
    logic hit;

    always_comb begin
        s_next = s_reg;
        m = mode;
        s_next.prev = sig;
        s_next.armed = 1'b1;
        // No edge is seen before the first sample after reset
        hit = s_reg.armed && ((m[0] && sig && !s_reg.prev) || (m[1] && !sig && s_reg.prev));
        if (sw_we) begin
            s_next.pend = sw_val;
        end else if (clr) begin
            s_next.pend = 1'b0;
        end
        // Event wins over any clear in the same cycle
        if (hit) begin
            s_next.pend = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pend = s_reg.pend;

endmodule

// ---- rtl/pdmm_params.svh ----
// Constants of the program and data memory map block
// Assumes inclusion by bare name from the package and the top module
`ifndef PDMM_PARAMS_SVH
`define PDMM_PARAMS_SVH

// Program counter and program word widths per variant
`define PDMM_PC_W_V0 10
`define PDMM_PC_W_V1 11
`define PDMM_PC_W_V2 12
`define PDMM_WORD_W_V0 14
`define PDMM_WORD_W_V1 15
`define PDMM_WORD_W_V2 15
`define PDMM_PM_DEPTH 4096

// Data memory bytes per variant
`define PDMM_DM_BYTES_V0 64
`define PDMM_DM_BYTES_V1 96
`define PDMM_DM_BYTES_V2 128

// Vector locations
`define PDMM_VEC_RESET 12'h000
`define PDMM_VEC_EXT 12'h004
`define PDMM_VEC_TM0 12'h008
`define PDMM_VEC_TM1 12'h00c
`define PDMM_VEC_TB 12'h010

// Special-function addresses
`define PDMM_SFR_BANK 8'h01
`define PDMM_SFR_TBLP 8'h02
`define PDMM_SFR_TABLE_HIGH_LATCH 8'h03
`define PDMM_SFR_INTC 8'h04
`define PDMM_SFR_INTF 8'h05
`define PDMM_SFR_EDGE 8'h06
`define PDMM_GP_START 8'h10

// Interrupt control field positions
`define PDMM_INTC_GIE 0
`define PDMM_INTC_EN_LSB 1

// Reset values
`define PDMM_TBLP_RST 8'h00
`define PDMM_TABLE_HIGH_LATCH_RST 8'h00
`define PDMM_INTC_RST 8'h00

`endif

// ---- rtl/pdmm_pkg.sv ----
// Types of the program and data memory map block
// Assumes pdmm_params.svh on the include path
`include "pdmm_params.svh"

package pdmm_pkg;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_STEP = 3'b001,
        OP_JUMP = 3'b010,
        OP_TBL_CUR = 3'b011,
        OP_TBL_LAST = 3'b100
    } pdmm_op_t;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } pdmm_edge_t;

    typedef enum logic {
        ST_RUN = 1'b0,
        ST_TABLE = 1'b1
    } pdmm_state_t;

    typedef struct packed {
        pdmm_op_t op;
        logic [11:0] target;
        logic [7:0] dest;
    } pdmm_seq_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic bset;
        logic bclr;
        logic ind;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [2:0] bitn;
    } pdmm_dm_req_t;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [14:0] data;
    } pdmm_prog_t;

    typedef struct packed {
        logic prev;
        logic armed;
        logic pend;
    } pdmm_isrc_t;

    typedef struct packed {
        pdmm_state_t state;
        logic [11:0] pc;
        logic [14:0] instr;
        logic instr_valid;
        logic busy;
        logic [7:0] rdata;
        logic rdata_valid;
        logic int_ack;
        logic [11:0] ret_pc;
        logic [7:0] tblp;
        logic [7:0] table_high_latch;
        logic [7:0] intc;
        pdmm_edge_t edge_sel;
        logic bank;
        logic [11:0] tbl_addr;
        logic [7:0] tbl_dest;
        logic ext_s1;
        logic ext_s2;
    } pdmm_core_t;

endpackage

// ---- rtl/pdmm_top.sv ----
// Program memory, data memory, table-read unit and interrupt vectoring
// Assumes a sequencer on sys_clk issuing one op per cycle and tracking the stack
//
// Summary of operation
// - Program memory is 1Kx14, 2Kx15 or 4Kx15 depending on variant.
// - Reset loads the program counter with the reset vector.
// - Enabled external edge branches to its vector unless the stack is full.
// - External active edge selectable: falling, rising or both.
// - Enabled timer overflow branches to that timer's vector unless stack full.
// - Enabled time base overflow branches to its vector unless stack full.
// - Table pointer gives low eight bits of every table-read address.
// - Current-page table read takes upper bits from the program counter.
// - Last-page table read forces every upper address bit to one.
// - Table address is 10, 11 or 12 bits per variant.
// - Table read puts low byte in named data register, high in latch.
// - Latch bits above the program word width read as zero.
// - Table high latch is read-only; only later table reads change it.
// - Each table read takes two instruction cycles.
// - Data memory is 8-bit RAM from 00H, special then general areas.
// - Data memory totals 64, 96 or 128 bytes per variant.
// - General-purpose locations are readable and writable.
// - Bit set and clear change one selected bit, except protected bits.
// - With two banks, direct reaches bank 0; bank 1 only indirectly.
// - Read-only special registers ignore writes; others read and write.
// - Unused special-function locations read as 00H.
// - With stack full a request stays latched; acknowledge waits for room.
`timescale 1ns/1ps
`include "pdmm_params.svh"

module pdmm_top #(
    parameter int VARIANT = 2,
    parameter int BANKS = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Program memory loading port
    input wire pdmm_pkg::pdmm_prog_t prog,
    // Sequencer requests
    input wire pdmm_pkg::pdmm_seq_req_t seq,
    input wire logic stack_full,
    input wire pdmm_pkg::pdmm_dm_req_t dm_req,
    // Interrupt sources
    input wire logic ext_int_pin,
    input wire logic tm0_ovf,
    input wire logic tm1_ovf,
    input wire logic tb_ovf,
    // Fetch answers
    output logic [11:0] pc,
    output logic [14:0] instr,
    output logic instr_valid,
    output logic table_busy,
    // Data answers
    output logic [7:0] rdata,
    output logic rdata_valid,
    // Interrupt acknowledge
    output logic int_ack,
    output logic [11:0] ret_pc
);

    // Variant-dependent sizes
    localparam int PC_W = (VARIANT == 0) ? `PDMM_PC_W_V0 :
        (VARIANT == 1) ? `PDMM_PC_W_V1 : `PDMM_PC_W_V2;
    localparam int WORD_W = (VARIANT == 0) ? `PDMM_WORD_W_V0 :
        (VARIANT == 1) ? `PDMM_WORD_W_V1 : `PDMM_WORD_W_V2;
    localparam int DM_BYTES = (VARIANT == 0) ? `PDMM_DM_BYTES_V0 :
        (VARIANT == 1) ? `PDMM_DM_BYTES_V1 : `PDMM_DM_BYTES_V2;
    localparam logic [11:0] PC_MASK = 12'((1 << PC_W) - 1);
    localparam logic [14:0] WORD_MASK = 15'((1 << WORD_W) - 1);
    localparam logic [8:0] DM_LIM = 9'(DM_BYTES);
    localparam logic BANK_ON = (BANKS == 2);

    // Reset state: reset vector, controls and flags off
    localparam pdmm_pkg::pdmm_core_t CORE_RST = '{
        state: pdmm_pkg::ST_RUN,
        pc: `PDMM_VEC_RESET,
        instr: 15'h0000,
        instr_valid: 1'b0,
        busy: 1'b0,
        rdata: 8'h00,
        rdata_valid: 1'b0,
        int_ack: 1'b0,
        ret_pc: 12'h000,
        tblp: `PDMM_TBLP_RST,
        table_high_latch: `PDMM_TABLE_HIGH_LATCH_RST,
        intc: `PDMM_INTC_RST,
        edge_sel: pdmm_pkg::EDGE_OFF,
        bank: 1'b0,
        tbl_addr: 12'h000,
        tbl_dest: 8'h00,
        ext_s1: 1'b0,
        ext_s2: 1'b0
    };

    pdmm_pkg::pdmm_core_t s_reg;
    pdmm_pkg::pdmm_core_t s_next;

    // Storage
    logic [14:0] pm [0:`PDMM_PM_DEPTH-1];
    logic [7:0] dm [0:255];

    // Helpers of the single next-state process
    logic [3:0] pend;
    logic [3:0] req;
    logic [3:0] grant;
    logic [3:0] src_sig;
    logic take;
    logic [11:0] vec;
    logic [11:0] pc_step;
    logic [14:0] word;
    logic [7:0] a;
    logic ind;
    logic gp_hit;
    logic [7:0] dm_idx;
    logic [7:0] rd_val;
    logic [7:0] bmask;
    logic [7:0] w_val;
    logic do_w;
    logic dm_we;
    logic flag_we;

    // Sources in order: external, timer 0, timer 1, time base
    assign src_sig = {tb_ovf, tm1_ovf, tm0_ovf, s_reg.ext_s2};

    // External source follows the edge select; the others latch rising edges
    for (genvar i = 0; i < 4; i++) begin : g_src
        pdmm_int_src u_src (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .sig(src_sig[i]),
            .mode((i == 0) ? s_reg.edge_sel : pdmm_pkg::EDGE_RISE),
            .clr(grant[i]),
            .sw_we(flag_we),
            .sw_val(w_val[i]),
            .pend(pend[i])
        );
    end

    always_comb begin
        s_next = s_reg;
        // Pin synchroniser
        s_next.ext_s1 = ext_int_pin;
        s_next.ext_s2 = s_reg.ext_s1;
        s_next.int_ack = 1'b0;
        s_next.rdata_valid = 1'b0;
        s_next.busy = 1'b0;

        // Interrupt arbitration, lowest source index first
        req = pend & s_reg.intc[`PDMM_INTC_EN_LSB +: 4] &
            {4{s_reg.intc[`PDMM_INTC_GIE]}};
        // Acknowledge waits for stack room and no branch in flight
        take = (s_reg.state == pdmm_pkg::ST_RUN) && !stack_full && (req != 4'h0) &&
            (seq.op == pdmm_pkg::OP_NONE || seq.op == pdmm_pkg::OP_STEP);
        grant = take ? (req & (~req + 4'h1)) : 4'h0;
        // Vector of the granted source
        case (grant)
            4'h1: vec = `PDMM_VEC_EXT;
            4'h2: vec = `PDMM_VEC_TM0;
            4'h4: vec = `PDMM_VEC_TM1;
            default: vec = `PDMM_VEC_TB;
        endcase

        // Sequential address wraps inside the variant's memory
        pc_step = (s_reg.pc + 12'h001) & PC_MASK;
        // Word beyond the variant width reads as zero
        word = pm[s_reg.tbl_addr] & WORD_MASK;

        // Table cycle owns the data port for its write-back
        if (s_reg.state == pdmm_pkg::ST_TABLE) begin
            a = s_reg.tbl_dest;
            ind = 1'b0;
        end else begin
            a = dm_req.addr;
            ind = dm_req.ind;
        end
        // Past the variant size is refused like a hole
        gp_hit = (a >= `PDMM_GP_START) && ({1'b0, a} < DM_LIM);
        dm_idx = {ind && BANK_ON && s_reg.bank, a[6:0]};

        rd_val = 8'h00;
        if (gp_hit) begin
            rd_val = dm[dm_idx];
        end else begin
            case (a)
                `PDMM_SFR_TBLP: rd_val = s_reg.tblp;
                `PDMM_SFR_TABLE_HIGH_LATCH: rd_val = s_reg.table_high_latch;
                `PDMM_SFR_INTC: rd_val = s_reg.intc;
                `PDMM_SFR_INTF: rd_val = {4'h0, pend};
                `PDMM_SFR_EDGE: rd_val = {6'h00, s_reg.edge_sel};
                `PDMM_SFR_BANK: rd_val = {7'h00, s_reg.bank};
                default: rd_val = 8'h00;
            endcase
        end

        // Bit operations read, modify and write in one cycle
        bmask = 8'h01 << dm_req.bitn;
        if (s_reg.state == pdmm_pkg::ST_TABLE) begin
            do_w = 1'b1;
            w_val = word[7:0];
        end else begin
            do_w = dm_req.wr || dm_req.bset || dm_req.bclr;
            if (dm_req.wr) begin
                w_val = dm_req.wdata;
            end else if (dm_req.bset) begin
                w_val = rd_val | bmask;
            end else begin
                w_val = rd_val & ~bmask;
            end
        end
        // Only the general area is backed by storage
        dm_we = do_w && gp_hit;
        flag_we = do_w && (a == `PDMM_SFR_INTF);

        // Latch address absent here, so writes to it fall through
        if (do_w) begin
            case (a)
                `PDMM_SFR_TBLP: s_next.tblp = w_val;
                `PDMM_SFR_INTC: s_next.intc = w_val;
                `PDMM_SFR_EDGE: s_next.edge_sel = pdmm_pkg::pdmm_edge_t'(w_val[1:0]);
                `PDMM_SFR_BANK: s_next.bank = w_val[0];
                default: ;
            endcase
        end

        // Read answered next cycle, never in a table cycle
        if (s_reg.state == pdmm_pkg::ST_RUN && dm_req.rd) begin
            s_next.rdata = rd_val;
            s_next.rdata_valid = 1'b1;
        end

        // Fetch, jump, table start and vectoring
        unique case (s_reg.state)
            pdmm_pkg::ST_RUN: begin
                s_next.instr_valid = 1'b1;
                if (take) begin
                    s_next.pc = vec;
                    s_next.int_ack = 1'b1;
                    // Return to the instruction that the branch displaced
                    s_next.ret_pc = (seq.op == pdmm_pkg::OP_STEP) ?
                        pc_step : s_reg.pc;
                end else begin
                    case (seq.op)
                        pdmm_pkg::OP_STEP: s_next.pc = pc_step;
                        pdmm_pkg::OP_JUMP: s_next.pc = seq.target & PC_MASK;
                        pdmm_pkg::OP_TBL_CUR: begin
                            s_next.pc = pc_step;
                            s_next.tbl_addr = {s_reg.pc[11:8], s_reg.tblp} & PC_MASK;
                            s_next.tbl_dest = seq.dest;
                            s_next.state = pdmm_pkg::ST_TABLE;
                            s_next.busy = 1'b1;
                            s_next.instr_valid = 1'b0;
                        end
                        pdmm_pkg::OP_TBL_LAST: begin
                            s_next.pc = pc_step;
                            s_next.tbl_addr = {4'hf, s_reg.tblp} & PC_MASK;
                            s_next.tbl_dest = seq.dest;
                            s_next.state = pdmm_pkg::ST_TABLE;
                            s_next.busy = 1'b1;
                            s_next.instr_valid = 1'b0;
                        end
                        default: ;
                    endcase
                end
                s_next.instr = pm[s_next.pc] & WORD_MASK;
            end
            pdmm_pkg::ST_TABLE: begin
                // Program port serves the table word this cycle
                s_next.table_high_latch = {1'b0, word[14:8]};
                s_next.instr_valid = 1'b0;
                s_next.state = pdmm_pkg::ST_RUN;
            end
        endcase
    end

    // Whole state resets together
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= CORE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Memories carry no reset; program words come from the loading port
    always_ff @(posedge sys_clk) begin
        if (prog.we) begin
            pm[prog.addr] <= prog.data;
        end
        if (dm_we) begin
            dm[dm_idx] <= w_val;
        end
    end

    // Outputs straight from the state register
    assign pc = s_reg.pc;
    assign instr = s_reg.instr;
    assign instr_valid = s_reg.instr_valid;
    assign table_busy = s_reg.busy;
    assign rdata = s_reg.rdata;
    assign rdata_valid = s_reg.rdata_valid;
    assign int_ack = s_reg.int_ack;
    assign ret_pc = s_reg.ret_pc;

endmodule

// ---- verification/pdmm_checker.sv ----
// Port assertions for pdmm_top
// Assumes one sys_clk domain with rstn asynchronous low
`timescale 1ns/1ps

module pdmm_checker #(
    parameter int VARIANT = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Requests
    input wire pdmm_pkg::pdmm_seq_req_t seq,
    input wire logic stack_full,
    input wire pdmm_pkg::pdmm_dm_req_t dm_req,
    // Answers
    input wire logic [11:0] pc,
    input wire logic instr_valid,
    input wire logic table_busy,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic int_ack,
    input wire logic [11:0] ret_pc
);
    localparam logic [11:0] PC_MASK = 12'(2 ** (10 + VARIANT) - 1);
    logic tbl_op;
    logic rd_go;
    assign tbl_op = seq.op inside {pdmm_pkg::OP_TBL_CUR, pdmm_pkg::OP_TBL_LAST};
    assign rd_go = dm_req.rd && !table_busy;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_RESET_PC: assert property (
        !$past(rstn) |-> pc == 12'h000) else $error("pc off reset vector");
    AST_TABLE_TWO: assert property (
        tbl_op && !table_busy |=> table_busy && !instr_valid ##1 !table_busy && !instr_valid)
        else $error("table read not two cycles");
    AST_VECTOR: assert property (
        int_ack |-> pc inside {12'h004, 12'h008, 12'h00c, 12'h010}) else $error("ack pc not a vector");
    AST_FULL_HOLD: assert property (
        stack_full |=> !int_ack) else $error("ack with stack full");
    AST_RET_NONE: assert property (
        int_ack && $past(seq.op) == pdmm_pkg::OP_NONE |-> ret_pc == $past(pc))
        else $error("bad return address");
    AST_READ_ANSWER: assert property (
        rd_go |=> rdata_valid) else $error("read not answered");
    AST_NO_READ: assert property (
        !rd_go |=> !rdata_valid) else $error("spurious read answer");
    AST_HOLE_ZERO: assert property (
        rd_go && !dm_req.ind && dm_req.addr inside {8'h00, [8'h07:8'h0f]} |=> rdata == 8'h00)
        else $error("unused location not zero");
    AST_LATCH_TOP: assert property (
        rd_go && dm_req.addr == 8'h03 |=> rdata[7] == 1'b0) else $error("latch top bit set");
    AST_JUMP: assert property (
        seq.op == pdmm_pkg::OP_JUMP && !table_busy |=> pc == ($past(seq.target) & PC_MASK))
        else $error("jump target wrong");

    COV_TABLE: cover property (tbl_op && !table_busy ##1 table_busy);
    COV_ACK: cover property (int_ack);
    COV_LATCH: cover property (rd_go && dm_req.addr == 8'h03 ##1 rdata_valid);
endmodule

bind pdmm_top pdmm_checker #(.VARIANT(VARIANT)) chk (
    .sys_clk(sys_clk), .rstn(rstn), .seq(seq), .stack_full(stack_full),
    .dm_req(dm_req), .pc(pc), .instr_valid(instr_valid), .table_busy(table_busy),
    .rdata(rdata), .rdata_valid(rdata_valid), .int_ack(int_ack), .ret_pc(ret_pc)
);

// ---- verification/pdmm_seq_model.sv ----
// Sequencer stand-in: return stack filled on acknowledge
// Assumes int_ack is a one-cycle pulse on sys_clk
`timescale 1ns/1ps

module pdmm_seq_model #(
    parameter int DEPTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Push and pop
    input wire logic int_ack,
    input wire logic pop,
    // Stack state
    output logic stack_full
);
    int level;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            level <= 0;
        end else if (int_ack) begin
            level <= level + 1;
        end else if (pop && level > 0) begin
            level <= level - 1;
        end
    end
    assign stack_full = level >= DEPTH;
endmodule

// ---- verification/pdmm_top_tb.sv ----
// Self-checking bench for pdmm_top
// Assumes pdmm_checker bound in and pdmm_seq_model as sequencer
`timescale 1ns/1ps

`define CHK(n, s, e) \
    begin \
        comparisons++; \
        if ((s) !== (e)) begin \
            bad_count++; \
            $display("mismatch %s expected %h seen %h", n, e, s); \
        end \
    end

module pdmm_top_tb;
    logic sys_clk;
    logic rstn;
    pdmm_pkg::pdmm_prog_t prog;
    pdmm_pkg::pdmm_seq_req_t seq;
    pdmm_pkg::pdmm_dm_req_t dm_req;
    logic stack_full;
    logic pop;
    logic [3:0] ev;
    logic ind_sel;
    logic [11:0] pc;
    logic [14:0] instr;
    logic instr_valid;
    logic table_busy;
    logic [7:0] rdata;
    logic rdata_valid;
    logic int_ack;
    logic [11:0] ret_pc;
    logic [7:0] holes [3] = '{8'h00, 8'h07, 8'h0f};
    int bad_count;
    int comparisons;
    int cycles;

    pdmm_top #(.BANKS(2)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .prog(prog), .seq(seq), .stack_full(stack_full),
        .dm_req(dm_req), .ext_int_pin(ev[0]), .tm0_ovf(ev[1]), .tm1_ovf(ev[2]), .tb_ovf(ev[3]),
        .pc(pc), .instr(instr), .instr_valid(instr_valid), .table_busy(table_busy),
        .rdata(rdata), .rdata_valid(rdata_valid), .int_ack(int_ack), .ret_pc(ret_pc)
    );
    pdmm_seq_model seq_model (
        .sys_clk(sys_clk), .rstn(rstn), .int_ack(int_ack), .pop(pop), .stack_full(stack_full)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
    endtask

    task automatic pw(input logic [11:0] a, input logic [14:0] d);
        @(posedge sys_clk);
        prog <= '{we: 1'b1, addr: a, data: d};
        @(posedge sys_clk);
        prog <= '0;
    endtask

    task automatic seq_op(input pdmm_pkg::pdmm_op_t o, input logic [11:0] t, input logic [7:0] d);
        @(posedge sys_clk);
        seq <= '{op: o, target: t, dest: d};
        @(posedge sys_clk);
        seq <= '0;
        #1;
    endtask

    task automatic dm(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
        @(posedge sys_clk);
        dm_req <= '{rd: k[3], wr: k[2], bset: k[1], bclr: k[0], ind: ind_sel, addr: a, wdata: d, bitn: b};
        @(posedge sys_clk);
        dm_req <= '0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dm(4'b0100, a, d, 3'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        dm(4'b1000, a, 8'h00, 3'h0);
        `CHK("rdata_valid", rdata_valid, 1'b1)
        `CHK("rdata", rdata, e)
    endtask

    task automatic drv(input logic [3:0] v);
        @(posedge sys_clk);
        ev <= v;
    endtask

    task automatic pop_one();
        @(posedge sys_clk);
        pop <= 1'b1;
        @(posedge sys_clk);
        pop <= 1'b0;
    endtask

    task automatic wack(input logic [11:0] v, input logic e);
        logic got;
        got = 1'b0;
        repeat (8) begin
            @(posedge sys_clk);
            #1;
            if (int_ack === 1'b1 && !got) begin
                got = 1'b1;
                `CHK("pc", pc, v)
            end
        end
        `CHK("int_ack", got, e)
    endtask

    task automatic t_reset();
        pw(12'h000, 15'h2a5b);
        do_reset();
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("pc", pc, 12'h000)
        `CHK("instr", instr, 15'h2a5b)
        `CHK("instr_valid", instr_valid, 1'b1)
    endtask

    task automatic t_fetch();
        pw(12'h100, 15'h7abc);
        seq_op(pdmm_pkg::OP_JUMP, 12'h0ff, 8'h00);
        `CHK("pc", pc, 12'h0ff)
        seq_op(pdmm_pkg::OP_STEP, 12'h000, 8'h00);
        `CHK("instr", instr, 15'h7abc)
    endtask

    task automatic t_table();
        wr(8'h02, 8'h45);
        pw(12'h345, 15'h6a5c);
        pw(12'hf45, 15'h7fa5);
        seq_op(pdmm_pkg::OP_JUMP, 12'h300, 8'h00);
        seq_op(pdmm_pkg::OP_TBL_CUR, 12'h000, 8'h10);
        `CHK("table_busy", table_busy, 1'b1)
        `CHK("instr_valid", instr_valid, 1'b0)
        @(posedge sys_clk);
        #1;
        `CHK("table_busy", table_busy, 1'b0)
        rd(8'h10, 8'h5c);
        rd(8'h03, 8'h6a);
        seq_op(pdmm_pkg::OP_TBL_LAST, 12'h000, 8'h11);
        rd(8'h11, 8'ha5);
        rd(8'h03, 8'h7f);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h7f);
        rd(8'h02, 8'h45);
    endtask

    task automatic t_data();
        wr(8'h7f, 8'ha5);
        rd(8'h7f, 8'ha5);
        dm(4'b0010, 8'h7f, 8'h00, 3'h1);
        rd(8'h7f, 8'ha7);
        dm(4'b0001, 8'h7f, 8'h00, 3'h0);
        rd(8'h7f, 8'ha6);
        wr(8'h80, 8'h11);
        rd(8'h80, 8'h00);
        foreach (holes[i]) begin
            rd(holes[i], 8'h00);
        end
        wr(8'h01, 8'h01);
        wr(8'h20, 8'h11);
        ind_sel = 1'b1;
        wr(8'h20, 8'h22);
        rd(8'h20, 8'h22);
        ind_sel = 1'b0;
        rd(8'h20, 8'h11);
        rd(8'h01, 8'h01);
        wr(8'h01, 8'h00);
    endtask

    task automatic t_irq();
        wr(8'h04, 8'h1f);
        wr(8'h06, 8'h01);
        drv(4'b0010);
        wack(12'h008, 1'b1);
        drv(4'b0100);
        wack(12'h00c, 1'b0);
        pop_one();
        wack(12'h00c, 1'b1);
        pop_one();
        drv(4'b1000);
        wack(12'h010, 1'b1);
        pop_one();
        drv(4'b0001);
        wack(12'h004, 1'b1);
        pop_one();
        drv(4'b0000);
        wack(12'h004, 1'b0);
        wr(8'h06, 8'h03);
        drv(4'b0001);
        wack(12'h004, 1'b1);
        pop_one();
        drv(4'b0000);
        wack(12'h004, 1'b1);
        pop_one();
        wr(8'h06, 8'h02);
        drv(4'b0001);
        wack(12'h004, 1'b0);
        drv(4'b0000);
        wack(12'h004, 1'b1);
        wr(8'h05, 8'h02);
        rd(8'h05, 8'h02);
        wr(8'h05, 8'h00);
        rd(8'h05, 8'h00);
    endtask

    initial begin
        rstn = 1'b0;
        prog = '0;
        seq = '0;
        dm_req = '0;
        ev = 4'h0;
        ind_sel = 1'b0;
        pop = 1'b0;
        do_reset();
        t_reset();
        t_fetch();
        t_table();
        t_data();
        t_irq();
        test_done();
    end
endmodule
